// File: core/dee_access_ctrl.sv
// data eeprom access control with axi4-lite register slave
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module dee_access_ctrl
   import dee_pkg::*;
#(
   parameter int ADDR_W = dee_pkg::ADDR_W_DEF,
   parameter int PROG_CYCLES = dee_pkg::PROG_CYCLES
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // system reset requests that abort a write
   input wire logic master_clear,
   input wire logic watchdog_timer,
   input wire logic brownout_reset,
   // write address channel
   input wire logic [dee_pkg::AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // write data channel
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // write response channel
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // read address channel
   input wire logic [dee_pkg::AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // read data channel
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // write-complete event for the interrupt controller
   output logic eeprom_done_flag
);
   import dee_pkg::*;

   generate
      if (ADDR_W < 1 || ADDR_W > DATA_W || PROG_CYCLES < 1) begin : g_bad_param
         $error("dee_access_ctrl: unsupported ADDR_W or PROG_CYCLES");
      end
   endgenerate

   dee_array_if #(.AW(ADDR_W)) arr ();

   dee_array #(
      .AW(ADDR_W),
      .PROG_CYCLES(PROG_CYCLES)
   ) u_array (
      .core_clk(core_clk),
      .resetn(resetn),
      .arr(arr.store)
   );

   // bus slave state
   logic aw_hold;
   logic w_hold;
   logic [AXI_AW-1:0] aw_addr_q;
   logic [7:0] w_data_q;
   logic w_strb_q;
   logic bvalid;
   logic [1:0] bresp;
   logic rvalid;
   logic [31:0] rdata;
   logic [1:0] rresp;
   logic rd_was_ctrl;

   // block registers
   logic [7:0] eeprom_byte_low;
   logic [7:0] eeprom_location_low;
   logic space_select;
   logic prog_abort_flag;
   logic prog_enable;
   logic write_start;
   logic done_flag;
   dee_unlock_t unlock_state;
   dee_unlock_t next_unlock;

   // write channel handshakes and the combined write strobe
   assign s_axi_awready = !aw_hold && !bvalid;
   assign s_axi_wready = !w_hold && !bvalid;
   wire wr_fire = aw_hold && w_hold;
   wire wen = wr_fire && w_strb_q;
   wire [7:0] wd = w_data_q;
   wire hit_byte = wen && (aw_addr_q == OFS_BYTE);
   wire hit_loc = wen && (aw_addr_q == OFS_LOC);
   wire hit_key = wen && (aw_addr_q == OFS_KEY);
   wire hit_done = wen && (aw_addr_q == OFS_DONE);
   wire hit_ctrl = wen && (aw_addr_q == OFS_CTRL);
   wire w_mapped = (aw_addr_q == OFS_BYTE) || (aw_addr_q == OFS_LOC) || (aw_addr_q == OFS_KEY)
      || (aw_addr_q == OFS_DONE) || (aw_addr_q == OFS_CTRL);

   // system resets other than power-on
   wire soft_rst = master_clear || watchdog_timer || brownout_reset;

   // control decode
   wire next_sel = wd[CTL_SEL];
   wire start_ok = hit_ctrl && wd[CTL_WR] && !write_start && prog_enable
      && (unlock_state == DEE_UL_AA) && !next_sel;
   wire rd_fire = hit_ctrl && wd[CTL_RD] && !next_sel;

   // unlock tracker: 55h, then AAh, then the start, with no other write between
   assign next_unlock = (hit_key && wd == KEY_FIRST) ? DEE_UL_55 :
      (hit_key && wd == KEY_SECOND && unlock_state == DEE_UL_55) ? DEE_UL_AA : DEE_UL_IDLE;

   // read mux; read trigger and unimplemented bits 6:4 of control read as zero
   wire [7:0] ctrl_view = {space_select, 3'b000, prog_abort_flag, prog_enable, write_start, 1'b0};
   wire ar_ctrl = (s_axi_araddr == OFS_CTRL);
   wire r_mapped = (s_axi_araddr == OFS_BYTE) || (s_axi_araddr == OFS_LOC) || (s_axi_araddr == OFS_KEY)
      || (s_axi_araddr == OFS_DONE) || ar_ctrl;
   wire [7:0] rd_byte = (s_axi_araddr == OFS_BYTE) ? eeprom_byte_low :
      (s_axi_araddr == OFS_LOC) ? eeprom_location_low :
      (s_axi_araddr == OFS_DONE) ? {7'h00, done_flag} :
      ar_ctrl ? ctrl_view : 8'h00;

   // array connections
   assign arr.rd_addr = eeprom_location_low[ADDR_W-1:0];
   assign arr.wr_addr = eeprom_location_low[ADDR_W-1:0];
   assign arr.wr_data = eeprom_byte_low;
   assign arr.start = start_ok;
   assign arr.abort = soft_rst;

   // port outputs
   assign s_axi_bvalid = bvalid;
   assign s_axi_bresp = bresp;
   assign s_axi_arready = !rvalid;
   assign s_axi_rvalid = rvalid;
   assign s_axi_rdata = rdata;
   assign s_axi_rresp = rresp;
   assign eeprom_done_flag = done_flag;

   // write address and data capture, response
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= 8'h00;
         w_strb_q <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold <= 1'b1;
            w_data_q <= s_axi_wdata[7:0];
            w_strb_q <= s_axi_wstrb[0];
         end
         if (wr_fire) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            bvalid <= 1'b1;
            bresp <= w_mapped ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid && s_axi_bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // read address and data
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
         rd_was_ctrl <= 1'b0;
      end else if (s_axi_arvalid && !rvalid) begin
         rvalid <= 1'b1;
         rdata <= {24'h00_0000, rd_byte};
         rresp <= r_mapped ? RESP_OKAY : RESP_SLVERR;
         rd_was_ctrl <= ar_ctrl;
      end else if (rvalid && s_axi_rready) begin
         rvalid <= 1'b0;
      end
   end

   // data and location registers
   always_ff @(posedge core_clk) begin
      if (!resetn || soft_rst) begin
         eeprom_byte_low <= REG_RST;
         eeprom_location_low <= REG_RST;
      end else begin
         if (rd_fire) begin
            eeprom_byte_low <= arr.rd_data;
         end else if (hit_byte) begin
            eeprom_byte_low <= wd;
         end
         if (hit_loc) begin
            eeprom_location_low <= wd;
         end
      end
   end

   // control bits, unlock tracker and done flag
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         space_select <= 1'b0;
         prog_enable <= 1'b0;
         prog_abort_flag <= 1'b0;
         write_start <= 1'b0;
         done_flag <= 1'b0;
         unlock_state <= DEE_UL_IDLE;
      end else if (soft_rst) begin
         space_select <= 1'b0;
         prog_enable <= 1'b0;
         prog_abort_flag <= prog_abort_flag || arr.busy;
         write_start <= 1'b0;
         done_flag <= 1'b0;
         unlock_state <= DEE_UL_IDLE;
      end else begin
         if (hit_ctrl) begin
            space_select <= next_sel;
            prog_enable <= wd[CTL_EN];
            prog_abort_flag <= wd[CTL_ERR];
         end
         if (start_ok) begin
            write_start <= 1'b1;
         end else if (arr.done) begin
            write_start <= 1'b0;
         end
         if (arr.done) begin
            done_flag <= 1'b1;
         end else if (hit_done && wd[DONE_BIT]) begin
            done_flag <= 1'b0;
         end
         if (wr_fire) begin
            unlock_state <= next_unlock;
         end
      end
   end

   // checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   property p_ctrl_unimpl_zero;
      rvalid && rd_was_ctrl && rresp == RESP_OKAY |-> rdata[6:4] == 3'b000 && rdata[0] == 1'b0;
   endproperty
   a_ctrl_unimpl_zero: assert property (p_ctrl_unimpl_zero) else $error("control unused bits not zero");

   property p_abort_sets_flag;
      soft_rst && arr.busy |=> prog_abort_flag && !write_start;
   endproperty
   a_abort_sets_flag: assert property (p_abort_sets_flag) else $error("aborted write did not flag");

   property p_start_needs_enable;
      $rose(write_start) |-> $past(prog_enable) && $past(unlock_state) == DEE_UL_AA;
   endproperty
   a_start_needs_enable: assert property (p_start_needs_enable) else $error("write start without unlock");

   property p_enable_kept;
      prog_enable && !hit_ctrl && !soft_rst |=> prog_enable;
   endproperty
   a_enable_kept: assert property (p_enable_kept) else $error("prog_enable cleared by hardware");

   property p_write_completes;
      write_start && !arr.done && !soft_rst |=> write_start;
   endproperty
   a_write_completes: assert property (p_write_completes) else $error("write start dropped early");

   property p_busy_runs;
      arr.busy && !soft_rst |=> arr.busy || arr.done;
   endproperty
   a_busy_runs: assert property (p_busy_runs) else $error("write cycle stopped early");

   property p_read_next_cycle;
      rd_fire && !soft_rst |=> eeprom_byte_low == $past(arr.rd_data);
   endproperty
   a_read_next_cycle: assert property (p_read_next_cycle) else $error("read byte not presented");

   property p_done_sets_flag;
      arr.done && !soft_rst |=> done_flag && !write_start;
   endproperty
   a_done_sets_flag: assert property (p_done_sets_flag) else $error("write end not reported");

   property p_program_space_refused;
      hit_ctrl && wd[CTL_SEL] && !write_start |=> !write_start;
   endproperty
   a_program_space_refused: assert property (p_program_space_refused) else $error("program space start");

   property p_byte_held;
      !rd_fire && !hit_byte && !soft_rst |=> $stable(eeprom_byte_low);
   endproperty
   a_byte_held: assert property (p_byte_held) else $error("data register changed");
endmodule // dee_access_ctrl
`default_nettype wire

// File: core/dee_array.sv
// nonvolatile byte array with self-timed write cycle
`timescale 1ns/10ps
`default_nettype none
module dee_array #(
   parameter int AW = 8,
   parameter int PROG_CYCLES = 100
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // control side
   dee_array_if.store arr
);
   localparam int CW = $clog2(PROG_CYCLES + 1);
   localparam logic [CW-1:0] CNT_LOAD = CW'(PROG_CYCLES - 1);

   logic [7:0] mem [2**AW];
   logic [CW-1:0] cnt;
   logic busy;
   logic done;
   logic [AW-1:0] lat_addr;
   logic [7:0] lat_data;
   wire last_cycle = busy && (cnt == '0) && !arr.abort;

   // asynchronous combinational read port
   assign arr.rd_data = mem[arr.rd_addr];
   assign arr.busy = busy;
   assign arr.done = done;

   // write timer; an abort ends the cycle without touching the cell
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         cnt <= '0;
         busy <= 1'b0;
         done <= 1'b0;
         lat_addr <= '0;
         lat_data <= 8'h00;
      end else begin
         done <= last_cycle;
         if (arr.abort) begin
            busy <= 1'b0;
            cnt <= '0;
         end else if (arr.start && !busy) begin
            busy <= 1'b1;
            cnt <= CNT_LOAD;
            lat_addr <= arr.wr_addr;
            lat_data <= arr.wr_data;
         end else if (busy) begin
            if (cnt == '0) begin
               busy <= 1'b0;
            end else begin
               cnt <= cnt - 1'b1;
            end
         end
      end
   end

   // cell programming at the end of the cycle
   always_ff @(posedge core_clk) begin
      if (last_cycle) begin
         mem[lat_addr] <= lat_data;
      end
   end
endmodule // dee_array
`default_nettype wire

// File: core/dee_array_if.sv
// connection between the control logic and the nonvolatile byte array
`timescale 1ns/10ps
`default_nettype none
interface dee_array_if #(parameter int AW = 8);
   logic [AW-1:0] rd_addr;
   logic [7:0] rd_data;
   logic start;
   logic [AW-1:0] wr_addr;
   logic [7:0] wr_data;
   logic abort;
   logic busy;
   logic done;
   modport ctrl (output rd_addr, start, wr_addr, wr_data, abort, input rd_data, busy, done);
   modport store (input rd_addr, start, wr_addr, wr_data, abort, output rd_data, busy, done);
endinterface
`default_nettype wire

// File: core/dee_pkg.sv
// constants, register map and types for the data eeprom access control block
`default_nettype none
package dee_pkg;
   // bus geometry
   localparam int AXI_AW = 12;
   localparam int DATA_W = 8;
   localparam int ADDR_W_DEF = 8;
   // register byte addresses
   localparam logic [AXI_AW-1:0] OFS_BYTE = 12'h100;
   localparam logic [AXI_AW-1:0] OFS_LOC = 12'h104;
   localparam logic [AXI_AW-1:0] OFS_KEY = 12'h108;
   localparam logic [AXI_AW-1:0] OFS_DONE = 12'h10c;
   localparam logic [AXI_AW-1:0] OFS_CTRL = 12'h18c;
   // control and done register fields
   localparam int CTL_RD = 0;
   localparam int CTL_WR = 1;
   localparam int CTL_EN = 2;
   localparam int CTL_ERR = 3;
   localparam int CTL_SEL = 7;
   localparam int DONE_BIT = 0;
   // unlock key bytes
   localparam logic [DATA_W-1:0] KEY_FIRST = 8'h55;
   localparam logic [DATA_W-1:0] KEY_SECOND = 8'haa;
   // reset value of every byte register
   localparam logic [DATA_W-1:0] REG_RST = 8'h00;
   // self-timed write duration
   localparam int CLK_PERIOD_NS = 50;
   localparam int PROG_TIME_NS = 5000;
   localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // unlock tracker states
   typedef enum logic [1:0] {
      DEE_UL_IDLE = 2'b00,
      DEE_UL_55 = 2'b01,
      DEE_UL_AA = 2'b10
   } dee_unlock_t;
endpackage
`default_nettype wire

// File: test/dee_host_model.sv
// axi4-lite host model standing in for the cpu core
`timescale 1ns/10ps
`default_nettype none
module dee_host_model
   import dee_pkg::*;
(
   // clock
   input wire logic core_clk,
   // write channels
   output logic [dee_pkg::AXI_AW-1:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   // read channels
   output logic [dee_pkg::AXI_AW-1:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   // idle bus at time zero
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
   end
   // one write, address and data offered together, each held until taken
   task automatic wr(input logic [AXI_AW-1:0] a, input logic [7:0] d, output logic [1:0] r);
      logic fin;
      fin = 1'b0;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_wstrb <= 4'h1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      while (!fin) begin
         @(posedge core_clk);
         if (s_axi_awvalid && s_axi_awready === 1'b1) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a; // released lines do not keep old value
         end
         if (s_axi_wvalid && s_axi_wready === 1'b1) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~s_axi_wdata;
         end
         if (s_axi_bvalid === 1'b1) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            fin = 1'b1;
         end
      end
   endtask
   // one read, byte taken at the edge where rvalid is seen
   task automatic rd(input logic [AXI_AW-1:0] a, output logic [7:0] d, output logic [1:0] r);
      logic fin;
      fin = 1'b0;
      @(posedge core_clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      while (!fin) begin
         @(posedge core_clk);
         if (s_axi_arvalid && s_axi_arready === 1'b1) begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr <= ~a;
         end
         if (s_axi_rvalid === 1'b1) begin
            d = s_axi_rdata[7:0];
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            fin = 1'b1;
         end
      end
   endtask
endmodule // dee_host_model
`default_nettype wire

// File: test/test_data_eeprom_access_control.sv
// self-checking bench for the data eeprom access control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin n_errors++; $display("Error %s exp %h got %h", n, e, s); end end
module test_data_eeprom_access_control;
   import dee_pkg::*;
   localparam int PC = 20;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic [2:0] abort_req = 3'h0;
   wire logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
   wire logic [31:0] s_axi_wdata, s_axi_rdata;
   wire logic [3:0] s_axi_wstrb;
   wire logic [1:0] s_axi_bresp, s_axi_rresp;
   wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, eeprom_done_flag;
   int n_errors = 0;
   int n_tests = 0;
   int cycles = 0;
   logic [1:0] r;
   logic [7:0] v;
   // block under test with a short write cycle
   dee_access_ctrl #(.ADDR_W(8), .PROG_CYCLES(PC)) dut (
      .core_clk, .resetn, .master_clear(abort_req[0]), .watchdog_timer(abort_req[1]),
      .brownout_reset(abort_req[2]), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .eeprom_done_flag);
   // cpu side
   dee_host_model host (
      .core_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   // 20 mhz clock
   always #25 core_clk = ~core_clk;
   // cycle ceiling against a hang
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors = n_errors + 1;
         final_report();
      end
   end
   task automatic w(input logic [AXI_AW-1:0] a, input logic [7:0] d);
      host.wr(a, d, r);
   endtask
   task automatic rc(input logic [AXI_AW-1:0] a, input logic [7:0] e, input string n);
      host.rd(a, v, r);
      `CHK(n, e, v)
   endtask
   // full write sequence, no other traffic in between, space_select clear
   task automatic prog(input logic [7:0] a, input logic [7:0] d);
      w(OFS_LOC, a);
      w(OFS_BYTE, d);
      w(OFS_CTRL, 8'h04);
      w(OFS_KEY, KEY_FIRST);
      w(OFS_KEY, KEY_SECOND);
      w(OFS_CTRL, 8'h06);
   endtask
   // bounded poll of the completion flag, at most 100 cycles, after a write is started
   task automatic wait_done();
      int k;
      k = 0;
      while (eeprom_done_flag !== 1'b1 && k < 100) begin
         @(posedge core_clk);
         k++;
      end
      `CHK("done port", 1'b1, eeprom_done_flag)
   endtask
   task automatic t_reset();
      rc(OFS_CTRL, 8'h00, "ctrl reset");
      w(OFS_CTRL, 8'h7c);
      rc(OFS_CTRL, 8'h0c, "ctrl 6:4");
      w(OFS_CTRL, 8'h00);
      host.wr(12'h0f0, 8'h5a, r);
      `CHK("unmapped bresp", RESP_SLVERR, r)
      host.rd(12'h0f0, v, r);
      `CHK("unmapped rresp", RESP_SLVERR, r)
      `CHK("unmapped rdata", 8'h00, v)
      $display("t_reset done");
   endtask
   task automatic t_write_read();
      prog(8'h21, 8'ha5);
      rc(OFS_CTRL, 8'h06, "write running");
      wait_done();
      rc(OFS_CTRL, 8'h04, "ctrl after write");
      repeat (5) @(posedge core_clk);
      rc(OFS_DONE, 8'h01, "done held");
      w(OFS_DONE, 8'h01);
      rc(OFS_DONE, 8'h00, "done cleared");
      w(OFS_BYTE, 8'h00);
      w(OFS_CTRL, 8'h01);
      rc(OFS_BYTE, 8'ha5, "read byte");
      rc(OFS_CTRL, 8'h00, "read trigger");
      w(OFS_LOC, 8'h99);
      rc(OFS_BYTE, 8'ha5, "byte held");
      w(OFS_BYTE, 8'h3c);
      w(OFS_CTRL, 8'h81);
      rc(OFS_BYTE, 8'h3c, "no read in prog space");
      w(OFS_CTRL, 8'h00);
      $display("t_write_read done");
   endtask
   task automatic t_refuse();
      w(OFS_LOC, 8'h21);
      w(OFS_BYTE, 8'h77);
      w(OFS_KEY, KEY_FIRST);
      w(OFS_KEY, KEY_SECOND);
      w(OFS_CTRL, 8'h06);
      rc(OFS_CTRL, 8'h04, "start without enable");
      w(OFS_KEY, KEY_FIRST);
      w(OFS_LOC, 8'h21);
      w(OFS_KEY, KEY_SECOND);
      w(OFS_CTRL, 8'h06);
      rc(OFS_CTRL, 8'h04, "broken unlock");
      w(OFS_KEY, KEY_FIRST);
      w(OFS_KEY, KEY_SECOND);
      w(OFS_CTRL, 8'h86);
      rc(OFS_CTRL, 8'h84, "start in prog space");
      w(OFS_CTRL, 8'h01);
      rc(OFS_BYTE, 8'ha5, "cell untouched");
      prog(8'h22, 8'h5e);
      w(OFS_CTRL, 8'h00);
      rc(OFS_CTRL, 8'h02, "zero to start");
      wait_done();
      rc(OFS_CTRL, 8'h00, "start cleared");
      w(OFS_DONE, 8'h01);
      w(OFS_LOC, 8'h22);
      w(OFS_CTRL, 8'h01);
      rc(OFS_BYTE, 8'h5e, "write completed");
      $display("t_refuse done");
   endtask
   // each reset source in turn cuts a running write short
   task automatic t_abort();
      for (int i = 0; i < 3; i++) begin
         prog(8'h30, 8'h11);
         wait_done();
         w(OFS_DONE, 8'h01);
         prog(8'h30, 8'hee);
         @(posedge core_clk);
         abort_req <= 3'(1 << i);
         @(posedge core_clk);
         abort_req <= 3'h0;
         // let the abandoned cycle's full length pass before judging
         repeat (PC) @(posedge core_clk);
         rc(OFS_CTRL, 8'h08, "abort flag");
         `CHK("done after abort", 1'b0, eeprom_done_flag)
         w(OFS_LOC, 8'h30);
         w(OFS_CTRL, 8'h01);
         rc(OFS_BYTE, 8'h11, "cell kept");
      end
      $display("t_abort done");
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (6) @(posedge core_clk);
      resetn <= 1'b1;
      t_reset();
      t_write_read();
      t_refuse();
      t_abort();
      final_report();
   end
endmodule // test_data_eeprom_access_control
`default_nettype wire
